// file: mfsr_pkg.sv
// Constants and carrier types for the modem FIFO status readback bank
package mfsr_pkg;
  // Register offsets, as printed
  localparam logic [7:0] MFSR_OFS_FIFO_PAIR_STATUS = 8'h2b;
  localparam logic [7:0] MFSR_OFS_CONVERTER_CODE = 8'h2c;
  // Field positions in the fifo_pair_status word
  localparam int MFSR_POS_RX_HALF_LSB = 12;
  localparam int MFSR_POS_RX_THR = 11;
  localparam int MFSR_POS_RX_FULL = 10;
  localparam int MFSR_POS_RX_EMPTY = 9;
  localparam int MFSR_POS_TX_HALF_LSB = 4;
  localparam int MFSR_POS_TX_THR = 3;
  localparam int MFSR_POS_TX_FULL = 2;
  localparam int MFSR_POS_TX_EMPTY = 1;
  // Reset values
  localparam logic [15:0] MFSR_RST_FIFO_PAIR_STATUS = 16'h0202;
  localparam logic [15:0] MFSR_RST_CONVERTER_CODE = 16'h0000;
  // Count width: bits 4..1 of the count form the half count
  localparam int MFSR_CNT_W = 5;
  localparam int MFSR_DEF_DEPTH = 16;
  // Queue indices for the generate loop
  localparam int MFSR_Q_RX = 0;
  localparam int MFSR_Q_TX = 1;
  // Flag group of one queue as it sits in the status word
  typedef struct packed {
    logic [3:0] half_count;
    logic threshold_flag;
    logic full_flag;
    logic empty_flag;
  } mfsr_qflags_t;
  // Read answer carrier
  typedef struct packed {
    logic valid;
    logic hit;
    logic [15:0] data;
  } mfsr_rd_resp_t;
endpackage

// file: mfsr_queue_flags.sv
// Flag encoder for one byte queue: half count, threshold, full, empty
`timescale 1ns/1ps
`default_nettype none
module mfsr_queue_flags
  import mfsr_pkg::*;
#(
  parameter int DEPTH = MFSR_DEF_DEPTH,
  parameter bit ABOVE = 1'b1
)
(
  input wire logic [MFSR_CNT_W-1:0] i_count,
  input wire logic [3:0] i_half_reported,
  output mfsr_qflags_t o_flags
);
  localparam logic [MFSR_CNT_W-1:0] DEPTH_CNT = MFSR_CNT_W'(DEPTH);

  // Threshold reference built from the half count last reported
  wire logic [MFSR_CNT_W-1:0] ref_above;
  wire logic [MFSR_CNT_W-1:0] ref_below;
  wire logic thr_hit;
  assign ref_above = {i_half_reported, 1'b1};
  assign ref_below = {i_half_reported, 1'b0};
  // Filling queue alarms on growth, draining queue on shrink
  assign thr_hit = ABOVE ? (i_count > ref_above) : (i_count < ref_below);

  // Flag group, straight from the live count
  assign o_flags.half_count = i_count[MFSR_CNT_W-1:1];
  assign o_flags.threshold_flag = thr_hit;
  assign o_flags.full_flag = (i_count == DEPTH_CNT);
  assign o_flags.empty_flag = (i_count == '0);
endmodule
`default_nettype wire

// file: mfsr_bank.sv
// Read-only status bank: both modem byte queues and the converter code
`timescale 1ns/1ps
`default_nettype none
module mfsr_bank
  import mfsr_pkg::*;
#(
  parameter int RX_DEPTH = MFSR_DEF_DEPTH,
  parameter int TX_DEPTH = MFSR_DEF_DEPTH
)
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_rd_strobe,
  input wire logic [7:0] i_rd_addr,
  input wire logic [MFSR_CNT_W-1:0] i_rx_count,
  input wire logic [MFSR_CNT_W-1:0] i_tx_count,
  input wire logic [15:0] i_converter_code,
  output logic o_rd_valid,
  output logic o_rd_hit,
  output logic [15:0] o_rd_data
);
  // Depth must fit the five-bit count and leave a meaningful half count
  if (RX_DEPTH < 2 || RX_DEPTH > 31 || TX_DEPTH < 2 || TX_DEPTH > 31)
  begin : g_depth_check
    $error("mfsr_bank: queue depth must lie in 2..31");
  end

  logic [15:0] status_q;
  logic [15:0] status_d;
  logic [15:0] code_q;
  mfsr_rd_resp_t resp_q;
  mfsr_rd_resp_t resp_d;
  mfsr_qflags_t qflags [2];
  wire logic [MFSR_CNT_W-1:0] qcount [2];
  wire logic [3:0] qreported [2];

  assign qcount[MFSR_Q_RX] = i_rx_count;
  assign qcount[MFSR_Q_TX] = i_tx_count;
  // Threshold compares against what software last could have seen
  assign qreported[MFSR_Q_RX] = status_q[MFSR_POS_RX_HALF_LSB +: 4];
  assign qreported[MFSR_Q_TX] = status_q[MFSR_POS_TX_HALF_LSB +: 4];

  // One flag encoder per queue; direction differs between the two
  for (genvar q = 0; q < 2; q++)
  begin : g_queue
    mfsr_queue_flags #(
      .DEPTH(q == MFSR_Q_RX ? RX_DEPTH : TX_DEPTH),
      .ABOVE(q == MFSR_Q_RX)
    ) u_flags (
      .i_count(qcount[q]),
      .i_half_reported(qreported[q]),
      .o_flags(qflags[q])
    );
  end

  // Status word assembly; reserved bits 8 and 0 stay zero
  assign status_d = {qflags[MFSR_Q_RX].half_count,
                     qflags[MFSR_Q_RX].threshold_flag,
                     qflags[MFSR_Q_RX].full_flag,
                     qflags[MFSR_Q_RX].empty_flag,
                     1'b0,
                     qflags[MFSR_Q_TX].half_count,
                     qflags[MFSR_Q_TX].threshold_flag,
                     qflags[MFSR_Q_TX].full_flag,
                     qflags[MFSR_Q_TX].empty_flag,
                     1'b0};

  // Address decode; unmapped offsets answer zero with hit low
  wire logic sel_status;
  wire logic sel_code;
  assign sel_status = (i_rd_addr == MFSR_OFS_FIFO_PAIR_STATUS);
  assign sel_code = (i_rd_addr == MFSR_OFS_CONVERTER_CODE);
  assign resp_d.valid = i_rd_strobe;
  assign resp_d.hit = i_rd_strobe & (sel_status | sel_code);
  // Pure mux: no pop, no clear, reading has no side effect
  assign resp_d.data = !i_rd_strobe ? 16'h0000 :
                       sel_status ? status_q :
                       sel_code ? code_q :
                       16'h0000;

  // Status snapshot, refreshed every cycle
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
      status_q <= MFSR_RST_FIFO_PAIR_STATUS;
    else
      status_q <= status_d;
  end

  // Converter code readback, read only from the bus side
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
      code_q <= MFSR_RST_CONVERTER_CODE;
    else
      code_q <= i_converter_code;
  end

  // Read answer register, one cycle after the strobe
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
      resp_q <= '0;
    else
      resp_q <= resp_d;
  end

  assign o_rd_valid = resp_q.valid;
  assign o_rd_hit = resp_q.hit;
  assign o_rd_data = resp_q.data;

  // Checks: status word follows the counts one cycle later
  property p_rx_half;
    @(posedge i_clock) disable iff (i_rst)
    !$past(i_rst) |-> status_q[15:12] == $past(i_rx_count[4:1]);
  endproperty
  a_rx_half: assert property (p_rx_half) else $error("rx half count wrong");

  property p_rx_thr;
    @(posedge i_clock) disable iff (i_rst)
    !$past(i_rst) |->
      status_q[11] == ($past(i_rx_count) > {$past(status_q[15:12]), 1'b1});
  endproperty
  a_rx_thr: assert property (p_rx_thr) else $error("rx threshold flag wrong");

  property p_rx_full;
    @(posedge i_clock) disable iff (i_rst)
    i_rx_count == MFSR_CNT_W'(RX_DEPTH) |=> status_q[10];
  endproperty
  a_rx_full: assert property (p_rx_full) else $error("rx full flag missing");

  property p_rx_empty;
    @(posedge i_clock) disable iff (i_rst)
    !$past(i_rst) |-> status_q[9] == ($past(i_rx_count) == '0);
  endproperty
  a_rx_empty: assert property (p_rx_empty) else $error("rx empty flag wrong");

  property p_tx_half;
    @(posedge i_clock) disable iff (i_rst)
    !$past(i_rst) |-> status_q[7:4] == $past(i_tx_count[4:1]);
  endproperty
  a_tx_half: assert property (p_tx_half) else $error("tx half count wrong");

  property p_tx_thr;
    @(posedge i_clock) disable iff (i_rst)
    !$past(i_rst) |->
      status_q[3] == ($past(i_tx_count) < {$past(status_q[7:4]), 1'b0});
  endproperty
  a_tx_thr: assert property (p_tx_thr) else $error("tx threshold flag wrong");

  property p_tx_full;
    @(posedge i_clock) disable iff (i_rst)
    i_tx_count != MFSR_CNT_W'(TX_DEPTH) |=> !status_q[2];
  endproperty
  a_tx_full: assert property (p_tx_full) else $error("tx full flag stuck");

  property p_tx_empty_rst;
    @(posedge i_clock)
    i_rst |=> status_q[1] && status_q[9] && status_q[8] == 1'b0;
  endproperty
  a_tx_empty_rst: assert property (p_tx_empty_rst) else $error("reset flags wrong");

  property p_code_read;
    @(posedge i_clock) disable iff (i_rst)
    i_rd_strobe && sel_code |=> o_rd_valid && o_rd_hit && o_rd_data == $past(code_q);
  endproperty
  a_code_read: assert property (p_code_read) else $error("code readback wrong");

  // A status read clears nothing: level and empty bits still follow the counts
  property p_read_quiet;
    @(posedge i_clock) disable iff (i_rst)
    i_rd_strobe && sel_status |=>
      status_q[15:12] == $past(i_rx_count[4:1]) && status_q[7:4] == $past(i_tx_count[4:1]) &&
      status_q[9] == ($past(i_rx_count) == '0) && status_q[1] == ($past(i_tx_count) == '0);
  endproperty
  a_read_quiet: assert property (p_read_quiet) else $error("read disturbed status");

  // Full clears as soon as one slot frees up
  property p_rx_not_full;
    @(posedge i_clock) disable iff (i_rst)
    i_rx_count != MFSR_CNT_W'(RX_DEPTH) |=> !status_q[10];
  endproperty
  a_rx_not_full: assert property (p_rx_not_full) else $error("rx full flag stuck");

  // Full shows one cycle after the last slot fills
  property p_tx_full_set;
    @(posedge i_clock) disable iff (i_rst)
    i_tx_count == MFSR_CNT_W'(TX_DEPTH) |=> status_q[2];
  endproperty
  a_tx_full_set: assert property (p_tx_full_set) else $error("tx full flag missing");

  // Empty tracks the live count, not only the reset value
  property p_tx_empty;
    @(posedge i_clock) disable iff (i_rst)
    !$past(i_rst) |-> status_q[1] == ($past(i_tx_count) == '0);
  endproperty
  a_tx_empty: assert property (p_tx_empty) else $error("tx empty flag wrong");

  // A status read returns the word held at the taking edge
  property p_status_read;
    @(posedge i_clock) disable iff (i_rst)
    i_rd_strobe && sel_status |=> o_rd_valid && o_rd_hit && o_rd_data == $past(status_q);
  endproperty
  a_status_read: assert property (p_status_read) else $error("status readback wrong");

  // Unmapped offsets answer zero with hit low
  property p_miss_read;
    @(posedge i_clock) disable iff (i_rst)
    i_rd_strobe && !sel_status && !sel_code |=>
      o_rd_valid && !o_rd_hit && o_rd_data == 16'h0000;
  endproperty
  a_miss_read: assert property (p_miss_read) else $error("unmapped read answered");

  // No strobe, no answer: outputs fall back to zero
  property p_idle_quiet;
    @(posedge i_clock) disable iff (i_rst)
    !i_rd_strobe |=> !o_rd_valid && !o_rd_hit && o_rd_data == 16'h0000;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("answer without read");

  // Answer comes exactly one cycle after the strobe
  property p_valid_after_read;
    @(posedge i_clock) disable iff (i_rst)
    i_rd_strobe |=> o_rd_valid;
  endproperty
  a_valid_after_read: assert property (p_valid_after_read) else $error("read not answered");

  // Hit is only meaningful alongside valid
  property p_hit_needs_valid;
    @(posedge i_clock) disable iff (i_rst)
    o_rd_hit |-> o_rd_valid;
  endproperty
  a_hit_needs_valid: assert property (p_hit_needs_valid) else $error("hit without valid");

  // Converter readback lags the applied code by one cycle
  property p_code_follow;
    @(posedge i_clock) disable iff (i_rst)
    !$past(i_rst) |-> code_q == $past(i_converter_code);
  endproperty
  a_code_follow: assert property (p_code_follow) else $error("code readback stale");

  // Reset quiets the read port and zeroes the readback
  property p_rst_outputs;
    @(posedge i_clock)
    i_rst |=> !o_rd_valid && !o_rd_hit && o_rd_data == 16'h0000 &&
      code_q == MFSR_RST_CONVERTER_CODE;
  endproperty
  a_rst_outputs: assert property (p_rst_outputs) else $error("reset outputs wrong");

  // Full and empty never show together, depth being two or more
  property p_rx_flags_excl;
    @(posedge i_clock) disable iff (i_rst)
    status_q[10] |-> !status_q[9];
  endproperty
  a_rx_flags_excl: assert property (p_rx_flags_excl) else $error("rx full and empty");

  // Same exclusion for the host-to-modem queue
  property p_tx_flags_excl;
    @(posedge i_clock) disable iff (i_rst)
    status_q[2] |-> !status_q[1];
  endproperty
  a_tx_flags_excl: assert property (p_tx_flags_excl) else $error("tx full and empty");

  // A full queue reports half its depth
  property p_rx_full_half;
    @(posedge i_clock) disable iff (i_rst)
    status_q[10] |-> status_q[15:12] == 4'(RX_DEPTH >> 1);
  endproperty
  a_rx_full_half: assert property (p_rx_full_half) else $error("rx full level wrong");

  // Same for the host-to-modem queue
  property p_tx_full_half;
    @(posedge i_clock) disable iff (i_rst)
    status_q[2] |-> status_q[7:4] == 4'(TX_DEPTH >> 1);
  endproperty
  a_tx_full_half: assert property (p_tx_full_half) else $error("tx full level wrong");

  // Empty means level zero and no growth alarm
  property p_rx_empty_half;
    @(posedge i_clock) disable iff (i_rst)
    status_q[9] |-> status_q[15:12] == 4'h0 && !status_q[11];
  endproperty
  a_rx_empty_half: assert property (p_rx_empty_half) else $error("rx empty level wrong");

  // Empty host-to-modem queue reports level zero
  property p_tx_empty_half;
    @(posedge i_clock) disable iff (i_rst)
    status_q[1] |-> status_q[7:4] == 4'h0;
  endproperty
  a_tx_empty_half: assert property (p_tx_empty_half) else $error("tx empty level wrong");

  // Main scenarios
  c_rx_full: cover property (@(posedge i_clock) disable iff (i_rst) status_q[10]);
  c_rx_thr: cover property (@(posedge i_clock) disable iff (i_rst) status_q[11]);
  c_tx_thr: cover property (@(posedge i_clock) disable iff (i_rst) status_q[3]);
  c_stat_rd: cover property (@(posedge i_clock) disable iff (i_rst)
    i_rd_strobe && sel_status ##1 o_rd_hit);
  c_miss_rd: cover property (@(posedge i_clock) disable iff (i_rst)
    o_rd_valid && !o_rd_hit);
endmodule
`default_nettype wire

// file: mfsr_host_model.sv
// Host-side read master model for the status bank
`timescale 1ns/1ps
`default_nettype none
module mfsr_host_model
(
  input wire logic i_clock,
  output logic o_rd_strobe,
  output logic [7:0] o_rd_addr
);
  initial
  begin
    o_rd_strobe = 1'b0;
    o_rd_addr = 8'h00;
  end
  // One read per cycle, changed just after the edge
  task automatic rd(input logic [7:0] addr);
    @(posedge i_clock);
    #1;
    o_rd_strobe = 1'b1;
    o_rd_addr = addr;
  endtask
  // Released lines show the inverse of the last address; a second idle in a row restores the old offset
  task automatic idle();
    @(posedge i_clock);
    #1;
    o_rd_strobe = 1'b0;
    o_rd_addr = ~o_rd_addr;
  endtask
endmodule
`default_nettype wire

// file: test_mfsr_bank.sv
// Self-checking bench for the modem FIFO status readback bank
`timescale 1ns/1ps
`default_nettype none
module test_mfsr_bank
  import mfsr_pkg::*;
;
  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  logic rd_strobe;
  logic [7:0] rd_addr;
  logic [4:0] rx_count;
  logic [4:0] tx_count;
  logic [15:0] conv_code;
  logic rd_valid;
  logic rd_hit;
  logic [15:0] rd_data;
  logic [15:0] stat_m;
  logic [15:0] conv_m;
  logic [16:0] expq[$];
  logic [16:0] e;
  logic [7:0] addrs[4] = '{8'h2b, 8'h2c, 8'h2a, 8'hff};
  logic [4:0] pairs[10] = '{5'h10, 5'h00, 5'h00, 5'h10, 5'h04, 5'h07, 5'h07, 5'h02, 5'h03, 5'h03};
  int fails = 0;
  int n_checks = 0;
  int cycles = 0;
  integer seed = 32'h8502;
  bit rnd_en = 1'b0;

  always #2.5 i_clock = ~i_clock;

  mfsr_host_model mfsr_host_model_i (.i_clock(i_clock), .o_rd_strobe(rd_strobe),
    .o_rd_addr(rd_addr));
  mfsr_bank mfsr_bank_i (.i_clock(i_clock), .i_rst(i_rst), .i_rd_strobe(rd_strobe),
    .i_rd_addr(rd_addr), .i_rx_count(rx_count), .i_tx_count(tx_count),
    .i_converter_code(conv_code), .o_rd_valid(rd_valid), .o_rd_hit(rd_hit),
    .o_rd_data(rd_data));

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] want);
    n_checks++;
    if (seen !== want)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", name, want, seen);
    end
  endtask

  task automatic conclude();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Mirror of the status word; the answer carries the value held before the edge
  always @(posedge i_clock)
  begin
    if (!i_rst && rd_strobe)
      expq.push_back({rd_addr == 8'h2b || rd_addr == 8'h2c,
        rd_addr == 8'h2b ? stat_m : (rd_addr == 8'h2c ? conv_m : 16'h0000)});
    stat_m <= i_rst ? 16'h0202 : {rx_count[4:1], rx_count > {stat_m[15:12], 1'b1},
      rx_count == 5'(MFSR_DEF_DEPTH), rx_count == 5'd0, 1'b0, tx_count[4:1],
      tx_count < {stat_m[7:4], 1'b0}, tx_count == 5'(MFSR_DEF_DEPTH), tx_count == 5'd0, 1'b0};
    conv_m <= i_rst ? 16'h0000 : conv_code;
  end

  // Random counts and code, legal depths only
  always @(posedge i_clock)
    if (rnd_en)
    begin
      #1;
      rx_count = 5'($unsigned($random(seed)) % 17);
      tx_count = 5'($unsigned($random(seed)) % 17);
      conv_code = 16'($random(seed));
    end

  // Compared mid-cycle so the edge's updates have landed
  always @(negedge i_clock)
  begin
    cycles++;
    if (cycles > 3000)
    begin
      fails++;
      conclude();
    end
    if (rd_valid === 1'b1)
    begin
      check("answer_expected", 16'(expq.size() != 0), 16'h0001);
      e = expq.size() != 0 ? expq.pop_front() : 17'h00000;
      check("rd_hit", 16'(rd_hit), 16'(e[16]));
      check("rd_data", rd_data, e[15:0]);
    end
    else
      check("idle_out", rd_data | 16'(rd_hit) | 16'(rd_valid), 16'h0000);
  end

  initial
  begin
    rx_count = 5'h00;
    tx_count = 5'h00;
    conv_code = 16'($random(seed));
    repeat (4) @(posedge i_clock);
    #1;
    i_rst = 1'b0;
    mfsr_host_model_i.rd(8'h2b);
    mfsr_host_model_i.rd(8'h2c);
    mfsr_host_model_i.idle();
    $display("reset values done");
    // Full, empty and threshold steps, read back to back
    for (int k = 0; k < 10; k += 2)
    begin
      mfsr_host_model_i.rd(8'h2b);
      rx_count = pairs[k];
      tx_count = pairs[k+1];
      repeat (2) mfsr_host_model_i.rd(8'h2b);
    end
    mfsr_host_model_i.idle();
    $display("boundary and threshold done");
    rnd_en = 1'b1;
    repeat (300)
      if ($unsigned($random(seed)) % 4 == 0)
        mfsr_host_model_i.idle();
      else
        mfsr_host_model_i.rd(addrs[$unsigned($random(seed)) % 4]);
    rnd_en = 1'b0;
    mfsr_host_model_i.idle();
    $display("random reads done");
    // Reset in mid-run with busy queues
    i_rst = 1'b1;
    repeat (2) @(posedge i_clock);
    #1;
    i_rst = 1'b0;
    mfsr_host_model_i.rd(8'h2b);
    mfsr_host_model_i.rd(8'h2c);
    repeat (3) mfsr_host_model_i.idle();
    $display("mid-run reset done");
    check("leftover", 16'(expq.size()), 16'h0000);
    conclude();
  end
endmodule
`default_nettype wire
